// ==== hw/gpio_status_fault_alert_pkg.sv ====
package gpio_status_fault_alert_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PIN_SETUP = 8'h33;
  localparam logic [7:0] ADDR_STATE = 8'h40;
  localparam logic [7:0] ADDR_FLAGS = 8'h41;
  localparam logic [7:0] ADDR_THIRD_CTL = 8'h42;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PIN_SETUP_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h80;
  localparam logic [7:0] THIRD_CTL_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Pin k (0 = third, 1 = second, 2 = first) uses setup bits [2k+3:2k+2]
  localparam int CFG_BASE = 2;
  localparam int PIN2_OUT_BIT = 1;
  // Pin k state and latched flag both sit at bit PIN_BIT_BASE + k
  localparam int PIN_BIT_BASE = 4;
  localparam int FLAG_RSVD_BIT = 7;
  localparam int FLAG_WAKE_BIT = 3;
  localparam int CTL_ALERT_BIT = 7;
  localparam int CTL_PULL_BIT = 6;

  // Secondary event enable bits
  localparam int EN_ADC_DONE = 7;
  localparam int EN_PIN1 = 6;
  localparam int EN_PIN2 = 5;
  localparam int EN_WAKE = 3;

  // Pin indices
  localparam int PIN_ONE = 2;
  localparam int PIN_TWO = 1;
  localparam int PIN_THREE = 0;
  localparam int NUM_PINS = 3;

  // ----------------------------------------------------------------
  // Pin mode encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_IN_HIGH = 2'b11,
    MODE_IN_LOW = 2'b10,
    MODE_OUT_B = 2'b01,
    MODE_OUT_A = 2'b00
  } pin_mode_t;

endpackage : gpio_status_fault_alert_pkg

// ==== hw/pin_level_decode.sv ====
`timescale 1ns/1ps

// Qualifies one pin against its two-bit mode field
module pin_level_decode (
  // Mode and pin level
  input wire logic [1:0] cfg_i,
  input wire logic level_i,
  // Decoded state
  output logic is_input_o,
  output logic active_o
);

  // Both input modes have the upper bit set; the lower bit is the active level
  assign is_input_o = cfg_i[1];
  assign active_o = cfg_i[1] & (level_i == cfg_i[0]);

endmodule : pin_level_decode

// ==== hw/gpio_status_fault_alert.sv ====
`timescale 1ns/1ps

// Functional notes
// - First pin mode: bits 7:6, default drive low
// - Second pin mode: bits 5:4, incl. gate input
// - Third pin mode: bits 3:2, incl. alert output
// - Second pin output follows setup bit one
// - State bit reads one at active level
// - Gate mode state bit follows gate input
// - Status shows ADC busy in snapshot mode
// - Status bits 2..0 show accumulator overflow
// - Latch flag when input pin was active
// - Latch wake flag when enabled bus wake
// - Latch flags on accumulator overflow
// - Alert mode pin low while alert bit
// - Alert bit set by event, host clears
// - Third pin output follows pull-down bit
// - Overflow alerts need their enable bit
module gpio_status_fault_alert (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Register port from the serial front end
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Open-drain general pins, index 2 first, 1 second, 0 third
  input wire logic [2:0] pin_in_i,
  output logic [2:0] pin_drive_o,
  output logic [2:0] pin_oe_n_o,
  // Status from measurement logic
  input wire logic adc_busy_snapshot_i,
  input wire logic adc_done_i,
  input wire logic [2:0] overflow_i,
  input wire logic stuck_wake_i,
  input wire logic control_b_wake_en_i,
  input wire logic [7:0] secondary_event_enable_i,
  input wire logic other_alert_i,
  // Outputs to the rest of the device
  output logic integrate_gate_o,
  output logic alert_flag_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] pin_setup;
  logic [7:0] latched_event_flags;
  logic ctl_alert;
  logic ctl_pull;
  logic [2:0] overflow_prev;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic wr_setup;
  logic wr_flags;
  logic wr_third;
  logic sel_setup;
  logic sel_state;
  logic sel_flags;
  logic sel_third;

  // Single-byte register port, one write strobe per writable byte; the state byte is read-only
  assign sel_setup = (reg_addr_i == gpio_status_fault_alert_pkg::ADDR_PIN_SETUP);
  assign sel_state = (reg_addr_i == gpio_status_fault_alert_pkg::ADDR_STATE);
  assign sel_flags = (reg_addr_i == gpio_status_fault_alert_pkg::ADDR_FLAGS);
  assign sel_third = (reg_addr_i == gpio_status_fault_alert_pkg::ADDR_THIRD_CTL);
  assign wr_setup = reg_wr_i & sel_setup;
  assign wr_flags = reg_wr_i & sel_flags;
  assign wr_third = reg_wr_i & sel_third;

  // ----------------------------------------------------------------
  // Pin decode
  // ----------------------------------------------------------------
  logic [2:0] pin_is_input;
  logic [2:0] pin_active;
  logic [1:0] cfg_one;
  logic [1:0] cfg_two;
  logic [1:0] cfg_three;

  // One decoder per pin; mode field of pin k sits two bits above pin k-1
  genvar k;
  generate
    for (k = 0; k < gpio_status_fault_alert_pkg::NUM_PINS; k++) begin : g_pin
      pin_level_decode u_decode (
        .cfg_i(pin_setup[gpio_status_fault_alert_pkg::CFG_BASE + 2 * k + 1 -: 2]),
        .level_i(pin_in_i[k]),
        .is_input_o(pin_is_input[k]),
        .active_o(pin_active[k])
      );
    end
  endgenerate

  assign cfg_one = pin_setup[7:6];
  assign cfg_two = pin_setup[5:4];
  assign cfg_three = pin_setup[3:2];

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic gate_mode;
  logic [2:0] next_drive;

  // Only the low level is ever driven; releasing leaves the pull-up to the board
  assign gate_mode = (cfg_two == gpio_status_fault_alert_pkg::MODE_OUT_A);
  assign next_drive[gpio_status_fault_alert_pkg::PIN_ONE] =
    (cfg_one == gpio_status_fault_alert_pkg::MODE_OUT_A);
  assign next_drive[gpio_status_fault_alert_pkg::PIN_TWO] =
    (cfg_two == gpio_status_fault_alert_pkg::MODE_OUT_B) &
    pin_setup[gpio_status_fault_alert_pkg::PIN2_OUT_BIT];
  assign next_drive[gpio_status_fault_alert_pkg::PIN_THREE] =
    ((cfg_three == gpio_status_fault_alert_pkg::MODE_OUT_B) & ctl_pull) |
    ((cfg_three == gpio_status_fault_alert_pkg::MODE_OUT_A) & ctl_alert);

  // ----------------------------------------------------------------
  // Status byte
  // ----------------------------------------------------------------
  logic [2:0] pin_state;
  logic [7:0] state_byte;

  // Second pin also reports the gate input level when in gate mode
  assign pin_state[gpio_status_fault_alert_pkg::PIN_ONE] = pin_active[gpio_status_fault_alert_pkg::PIN_ONE];
  assign pin_state[gpio_status_fault_alert_pkg::PIN_TWO] =
    pin_active[gpio_status_fault_alert_pkg::PIN_TWO] |
    (gate_mode & pin_in_i[gpio_status_fault_alert_pkg::PIN_TWO]);
  assign pin_state[gpio_status_fault_alert_pkg::PIN_THREE] = pin_active[gpio_status_fault_alert_pkg::PIN_THREE];
  assign state_byte = {1'b0, pin_state, adc_busy_snapshot_i, overflow_i};

  // ----------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------
  logic [2:0] overflow_rise;
  logic wake_set;
  logic [7:0] flag_set;
  logic [7:0] flags_kept;
  logic [7:0] next_flags;
  logic alert_event;
  logic next_alert;
  logic next_pull;

  // Overflow is a level; only its rising edge counts as a new event
  assign overflow_rise = overflow_i & ~overflow_prev;
  assign wake_set = stuck_wake_i & control_b_wake_en_i;
  assign flag_set = {1'b0, pin_active, wake_set, overflow_rise};

  // Host clears by writing zero; writing one leaves a flag as it was
  assign flags_kept = wr_flags ? (latched_event_flags & reg_wdata_i) : latched_event_flags;
  // Set wins over a clear in the same cycle; reserved top bit stays one
  assign next_flags = flags_kept | flag_set | gpio_status_fault_alert_pkg::FLAGS_RESET;

  // Every source of the alert bit; all but other_alert_i are gated by their own enable
  assign alert_event = other_alert_i |
    (adc_done_i & secondary_event_enable_i[gpio_status_fault_alert_pkg::EN_ADC_DONE]) |
    (pin_active[gpio_status_fault_alert_pkg::PIN_ONE] &
     secondary_event_enable_i[gpio_status_fault_alert_pkg::EN_PIN1]) |
    (pin_active[gpio_status_fault_alert_pkg::PIN_TWO] &
     secondary_event_enable_i[gpio_status_fault_alert_pkg::EN_PIN2]) |
    (wake_set & secondary_event_enable_i[gpio_status_fault_alert_pkg::EN_WAKE]) |
    (|(overflow_rise & secondary_event_enable_i[2:0]));

  // Write of one sets, write of zero clears, a new alert always wins
  assign next_alert = (wr_third ? reg_wdata_i[gpio_status_fault_alert_pkg::CTL_ALERT_BIT] : ctl_alert) |
    alert_event;
  assign next_pull = wr_third ? reg_wdata_i[gpio_status_fault_alert_pkg::CTL_PULL_BIT] : ctl_pull;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;

  // Unmapped addresses read zero; the low control bits are fixed at zero
  assign next_rdata = sel_setup ? pin_setup :
                      sel_state ? state_byte :
                      sel_flags ? latched_event_flags :
                      sel_third ? {ctl_alert, ctl_pull, 6'h00} :
                      gpio_status_fault_alert_pkg::RDATA_RESET;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  // Setup register; bit zero is reserved and kept at zero
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pin_setup <= gpio_status_fault_alert_pkg::PIN_SETUP_RESET;
    end else if (wr_setup) begin
      pin_setup <= {reg_wdata_i[7:1], 1'b0};
    end
  end

  // Latched flags and edge history
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      latched_event_flags <= gpio_status_fault_alert_pkg::FLAGS_RESET;
      overflow_prev <= 3'h0;
    end else begin
      latched_event_flags <= next_flags;
      overflow_prev <= overflow_i;
    end
  end

  // Third pin control bits
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ctl_alert <= gpio_status_fault_alert_pkg::THIRD_CTL_RESET[gpio_status_fault_alert_pkg::CTL_ALERT_BIT];
      ctl_pull <= gpio_status_fault_alert_pkg::THIRD_CTL_RESET[gpio_status_fault_alert_pkg::CTL_PULL_BIT];
    end else begin
      ctl_alert <= next_alert;
      ctl_pull <= next_pull;
    end
  end

  // ----------------------------------------------------------------
  // Output flops
  // ----------------------------------------------------------------
  // First pin comes up driven low from its default mode, the other two released, as the reset map implies
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pin_oe_n_o <= 3'h3;
      pin_drive_o <= 3'h0;
      reg_rdata_o <= gpio_status_fault_alert_pkg::RDATA_RESET;
      integrate_gate_o <= 1'b0;
      alert_flag_o <= 1'b0;
    end else begin
      pin_oe_n_o <= ~next_drive;
      pin_drive_o <= 3'h0;
      reg_rdata_o <= next_rdata;
      integrate_gate_o <= gate_mode & pin_in_i[gpio_status_fault_alert_pkg::PIN_TWO];
      alert_flag_o <= ctl_alert;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb_main @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);

  // Drive-low mode pulls the first pin one cycle later
  AST_PIN1_DRIVE_LOW: assert property (
    (cfg_one == 2'b00) |=> !pin_oe_n_o[2]
  ) else $error("first pin not driven low in drive-low mode");

  // Second pin output mode follows setup bit one
  AST_PIN2_OUTPUT: assert property (
    (cfg_two == 2'b01) |=> (pin_oe_n_o[1] == !$past(pin_setup[1]))
  ) else $error("second pin output does not follow setup bit one");

  // Alert mode pulls the third pin while the alert bit is set
  AST_PIN3_ALERT: assert property (
    (cfg_three == 2'b00) |=> (pin_oe_n_o[0] == !$past(ctl_alert))
  ) else $error("third pin does not follow alert bit");

  // Output mode of the third pin follows the pull-down bit
  AST_PIN3_PULL: assert property (
    (cfg_three == 2'b01) |=> (pin_oe_n_o[0] == !$past(ctl_pull))
  ) else $error("third pin does not follow pull-down bit");

  // Input modes never drive any pin
  AST_INPUT_RELEASED: assert property (
    1'b1 |=> ((~pin_oe_n_o & $past(pin_is_input)) == 3'h0)
  ) else $error("pin driven while in input mode");

  // Active-low first pin reads one when low
  AST_STATE_ACTIVE_LOW: assert property (
    (sel_state && cfg_one == 2'b10) |=> (reg_rdata_o[6] == !$past(pin_in_i[2]))
  ) else $error("active-low state bit wrong");

  // Gate mode state bit follows the gate input
  AST_GATE_STATE: assert property (
    (sel_state && cfg_two == 2'b00) |=> (reg_rdata_o[5] == $past(pin_in_i[1]))
  ) else $error("gate input state bit wrong");

  // Busy and overflow read back as presented
  AST_STATUS_LOW: assert property (
    sel_state |=> (reg_rdata_o[3:0] == {$past(adc_busy_snapshot_i), $past(overflow_i)})
  ) else $error("busy or overflow status wrong");

  // Active input latches its flag next cycle
  AST_PIN_FLAG_SET: assert property (
    pin_active[2] |=> latched_event_flags[6]
  ) else $error("first pin flag not latched");

  // Enabled bus wake latches the wake flag
  AST_WAKE_FLAG: assert property (
    (stuck_wake_i && control_b_wake_en_i) |=> latched_event_flags[3]
  ) else $error("wake flag not latched");

  // Overflow edge latches its flag
  AST_OVF_FLAG: assert property (
    (overflow_i[2] && !overflow_prev[2]) |=> latched_event_flags[2]
  ) else $error("energy overflow flag not latched");

  // Alert event sets the alert bit even during a clearing write
  AST_ALERT_SET: assert property (
    alert_event |=> ctl_alert
  ) else $error("alert bit not set by event");

  // With every enable clear only the primary source may raise the alert bit
  AST_OVF_GATED: assert property (
    (!ctl_alert && !wr_third && !other_alert_i && (secondary_event_enable_i == 8'h00)) |=> !ctl_alert
  ) else $error("alert raised without enable");

  // Flag bit zero holds for two cycles without a write
  AST_FLAG_HOLD: assert property (
    (latched_event_flags[0] && !wr_flags) ##1 !wr_flags |=> latched_event_flags[0]
  ) else $error("latched flag dropped without host clear");

  // Gate input is passed on only in gate mode, one cycle late
  AST_GATE_OUT: assert property (
    (cfg_two == 2'h0) |=> (integrate_gate_o == $past(pin_in_i[1]))
  ) else $error("gate output does not follow second pin");

  // Outside gate mode the gate output stays low
  AST_GATE_OFF: assert property (
    (cfg_two != 2'h0) |=> !integrate_gate_o
  ) else $error("gate output active outside gate mode");

  // Host write of zero clears the alert bit when no event competes
  AST_ALERT_CLEAR: assert property (
    (wr_third && !reg_wdata_i[7] && !alert_event) |=> !ctl_alert
  ) else $error("alert bit not cleared by host");

  // Alert bit holds until the host writes the control byte
  AST_ALERT_HOLD: assert property (
    (ctl_alert && !wr_third) |=> ctl_alert
  ) else $error("alert bit dropped without host clear");

  // Without the wake option a bus wake never latches its flag
  AST_WAKE_BLOCKED: assert property (
    (!control_b_wake_en_i && !latched_event_flags[3]) |=> !latched_event_flags[3]
  ) else $error("wake flag latched without wake option");

  COV_GATE_INPUT: cover property (
    (cfg_two == 2'h0) ##1 integrate_gate_o ##1 !integrate_gate_o
  );
  COV_ALERT_PIN: cover property (
    (cfg_three == 2'b00) ##1 ctl_alert ##1 !pin_oe_n_o[0]
  );
  COV_FLAG_CLEAR: cover property (
    latched_event_flags[2] ##1 wr_flags ##1 !latched_event_flags[2]
  );
  COV_SET_BEATS_CLEAR: cover property (
    wr_third && !reg_wdata_i[7] && alert_event
  );

endmodule : gpio_status_fault_alert

// ==== verif/pin_partner.sv ====
`timescale 1ns/1ps

// Board around the three open-drain general pins
module pin_partner (
  // Device side of each pin
  input wire logic [2:0] pin_drive_i,
  input wire logic [2:0] pin_oe_n_i,
  // Board switches that pull a pin low
  input wire logic [2:0] ext_low_i,
  // Resolved wire levels
  output logic [2:0] level_o
);
  // Pull-up wins only when nobody pulls low, so a released pin never keeps a stale level
  assign level_o = ~((~pin_oe_n_i & ~pin_drive_i) | ext_low_i);
endmodule : pin_partner

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps

module tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ref_clk_i, srst_i, reg_wr_i, adc_busy, adc_done, stuck_wake, wake_en, other_alert;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, sec_en;
  logic [2:0] ovf, ext_low, level, pin_drive_o, pin_oe_n_o;
  logic integrate_gate_o, alert_flag_o;
  int fails, compares;

  gpio_status_fault_alert dut_u (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .pin_in_i(level), .pin_drive_o(pin_drive_o), .pin_oe_n_o(pin_oe_n_o),
    .adc_busy_snapshot_i(adc_busy), .adc_done_i(adc_done), .overflow_i(ovf),
    .stuck_wake_i(stuck_wake), .control_b_wake_en_i(wake_en),
    .secondary_event_enable_i(sec_en), .other_alert_i(other_alert),
    .integrate_gate_o(integrate_gate_o), .alert_flag_o(alert_flag_o)
  );

  pin_partner board_u (
    .pin_drive_i(pin_drive_o), .pin_oe_n_i(pin_oe_n_o), .ext_low_i(ext_low), .level_o(level)
  );

  // Free-running 50 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : idle

  // Write strobe lasts one cycle, so back-to-back calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  // Read data is registered: look one edge after the address is set
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    #1 chk(reg_rdata_o, e);
  endtask : rd

  // Pin enables settle two edges after the write that moves them
  task automatic pin(input logic [7:0] e);
    idle(2);
    #1 chk({5'h00, pin_oe_n_o}, e);
    chk({5'h00, pin_drive_o}, 8'h00);
  endtask : pin

  task automatic end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    fails = 0;
    compares = 0;
    srst_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    adc_busy = 1'b0;
    adc_done = 1'b0;
    stuck_wake = 1'b0;
    wake_en = 1'b0;
    other_alert = 1'b0;
    sec_en = 8'h00;
    ovf = 3'h0;
    ext_low = 3'h0;
    idle(10);
    srst_i <= 1'b0;
    // Reset state and an unmapped address
    pin(8'h03);
    rd(gpio_status_fault_alert_pkg::ADDR_PIN_SETUP, 8'h00);
    rd(gpio_status_fault_alert_pkg::ADDR_FLAGS, 8'h80);
    rd(gpio_status_fault_alert_pkg::ADDR_THIRD_CTL, 8'h00);
    rd(8'h7F, 8'h00);
    rd(gpio_status_fault_alert_pkg::ADDR_STATE, 8'h20);
    chk({7'h00, integrate_gate_o}, 8'h01);
    @(posedge ref_clk_i) ext_low <= 3'h2;
    rd(gpio_status_fault_alert_pkg::ADDR_STATE, 8'h00);
    chk({7'h00, integrate_gate_o}, 8'h00);
    // First and second pin output modes; reserved bit stays 0
    wr(gpio_status_fault_alert_pkg::ADDR_PIN_SETUP, 8'h40);
    pin(8'h07);
    wr(gpio_status_fault_alert_pkg::ADDR_PIN_SETUP, 8'h13);
    rd(gpio_status_fault_alert_pkg::ADDR_PIN_SETUP, 8'h12);
    pin(8'h01);
    wr(gpio_status_fault_alert_pkg::ADDR_PIN_SETUP, 8'h10);
    pin(8'h03);
    // Third pin as output, then as input where the pull bit is ignored
    wr(gpio_status_fault_alert_pkg::ADDR_PIN_SETUP, 8'h04);
    wr(gpio_status_fault_alert_pkg::ADDR_THIRD_CTL, 8'h40);
    pin(8'h02);
    wr(gpio_status_fault_alert_pkg::ADDR_THIRD_CTL, 8'h00);
    pin(8'h03);
    wr(gpio_status_fault_alert_pkg::ADDR_PIN_SETUP, 8'h0C);
    wr(gpio_status_fault_alert_pkg::ADDR_THIRD_CTL, 8'h7F);
    rd(gpio_status_fault_alert_pkg::ADDR_THIRD_CTL, 8'h40);
    pin(8'h03);
    // Alert output mode against general output mode
    wr(gpio_status_fault_alert_pkg::ADDR_PIN_SETUP, 8'h00);
    wr(gpio_status_fault_alert_pkg::ADDR_THIRD_CTL, 8'h80);
    pin(8'h02);
    chk({7'h00, alert_flag_o}, 8'h01);
    wr(gpio_status_fault_alert_pkg::ADDR_PIN_SETUP, 8'h04);
    pin(8'h03);
    wr(gpio_status_fault_alert_pkg::ADDR_THIRD_CTL, 8'h00);
    wr(gpio_status_fault_alert_pkg::ADDR_PIN_SETUP, 8'h00);
    rd(gpio_status_fault_alert_pkg::ADDR_THIRD_CTL, 8'h00);
    pin(8'h03);
    chk({7'h00, alert_flag_o}, 8'h00);
    // Inputs of both polarities; flags hold after the level goes away
    @(posedge ref_clk_i) ext_low <= 3'h0;
    wr(gpio_status_fault_alert_pkg::ADDR_PIN_SETUP, 8'hEC);
    idle(2);
    rd(gpio_status_fault_alert_pkg::ADDR_STATE, 8'h50);
    rd(gpio_status_fault_alert_pkg::ADDR_FLAGS, 8'hD0);
    @(posedge ref_clk_i) ext_low <= 3'h7;
    idle(2);
    rd(gpio_status_fault_alert_pkg::ADDR_STATE, 8'h20);
    @(posedge ref_clk_i) ext_low <= 3'h5;
    idle(2);
    rd(gpio_status_fault_alert_pkg::ADDR_STATE, 8'h00);
    rd(gpio_status_fault_alert_pkg::ADDR_FLAGS, 8'hF0);
    wr(gpio_status_fault_alert_pkg::ADDR_FLAGS, 8'hEF);
    rd(gpio_status_fault_alert_pkg::ADDR_FLAGS, 8'hE0);
    wr(gpio_status_fault_alert_pkg::ADDR_FLAGS, 8'h00);
    // Overflow status, flags and gated alerts
    ovf <= 3'h7;
    idle(2);
    rd(gpio_status_fault_alert_pkg::ADDR_STATE, 8'h07);
    rd(gpio_status_fault_alert_pkg::ADDR_THIRD_CTL, 8'h00);
    @(posedge ref_clk_i) ovf <= 3'h0;
    idle(2);
    rd(gpio_status_fault_alert_pkg::ADDR_STATE, 8'h00);
    rd(gpio_status_fault_alert_pkg::ADDR_FLAGS, 8'h87);
    wr(gpio_status_fault_alert_pkg::ADDR_FLAGS, 8'h00);
    sec_en <= 8'h04;
    ovf <= 3'h2;
    idle(3);
    rd(gpio_status_fault_alert_pkg::ADDR_THIRD_CTL, 8'h00);
    @(posedge ref_clk_i) ovf <= 3'h6;
    idle(3);
    rd(gpio_status_fault_alert_pkg::ADDR_THIRD_CTL, 8'h80);
    wr(gpio_status_fault_alert_pkg::ADDR_THIRD_CTL, 8'h00);
    rd(gpio_status_fault_alert_pkg::ADDR_FLAGS, 8'h86);
    // Snapshot busy level
    @(posedge ref_clk_i) adc_busy <= 1'b1;
    idle(2);
    rd(gpio_status_fault_alert_pkg::ADDR_STATE, 8'h0E);
    // Wake flag only with the wake option set
    wr(gpio_status_fault_alert_pkg::ADDR_FLAGS, 8'h00);
    @(posedge ref_clk_i) stuck_wake <= 1'b1;
    @(posedge ref_clk_i) stuck_wake <= 1'b0;
    rd(gpio_status_fault_alert_pkg::ADDR_FLAGS, 8'h80);
    @(posedge ref_clk_i) wake_en <= 1'b1;
    @(posedge ref_clk_i) stuck_wake <= 1'b1;
    @(posedge ref_clk_i) stuck_wake <= 1'b0;
    rd(gpio_status_fault_alert_pkg::ADDR_FLAGS, 8'h88);
    // Conversion-done alert and the primary alert source
    @(posedge ref_clk_i) sec_en <= 8'h80;
    @(posedge ref_clk_i) adc_done <= 1'b1;
    @(posedge ref_clk_i) adc_done <= 1'b0;
    rd(gpio_status_fault_alert_pkg::ADDR_THIRD_CTL, 8'h80);
    wr(gpio_status_fault_alert_pkg::ADDR_THIRD_CTL, 8'h00);
    @(posedge ref_clk_i) other_alert <= 1'b1;
    @(posedge ref_clk_i) other_alert <= 1'b0;
    rd(gpio_status_fault_alert_pkg::ADDR_THIRD_CTL, 8'h80);
    // Pin input alert follows the first pin's active level and its enable
    wr(gpio_status_fault_alert_pkg::ADDR_THIRD_CTL, 8'h00);
    @(posedge ref_clk_i) sec_en <= 8'h40;
    rd(gpio_status_fault_alert_pkg::ADDR_THIRD_CTL, 8'h00);
    @(posedge ref_clk_i) ext_low <= 3'h0;
    idle(2);
    rd(gpio_status_fault_alert_pkg::ADDR_THIRD_CTL, 8'h80);
    end_sim();
  end
endmodule : tb_top
